// ===== shared/csm_defines.svh
// Offsets, field positions, reset values and sizes of the status mirror
`ifndef CSM_DEFINES_SVH
`define CSM_DEFINES_SVH

// Register bus geometry
`define CSM_ADDR_W          8
`define CSM_DATA_W          32

// Register offsets (byte addresses, one aligned word each)
`define CSM_OFS_MODE        8'h00
`define CSM_OFS_LINKCTL_PF0 8'h10
`define CSM_OFS_LINKCTL_PF1 8'h14
`define CSM_OFS_DEVCTL2     8'h20
`define CSM_OFS_DPACTL_PF0  8'h30
`define CSM_OFS_DPACTL_PF1  8'h34
`define CSM_OFS_LINKCTL3    8'h40
`define CSM_OFS_LINKSTS     8'h44
`define CSM_OFS_LINKSTS2    8'h48
`define CSM_OFS_TPH_BASE    8'h80
`define CSM_TPH_MASK        8'hE3
`define CSM_TPH_IDX_LSB     2
`define CSM_TPH_IDX_MSB     4

// Function counts
`define CSM_NUM_PF          2
`define CSM_NUM_VF          6
`define CSM_NUM_TPH         8

// Field positions
`define CSM_BIT_ROOT        0
`define CSM_BIT_RCB         3
`define CSM_BIT_BW_MGMT_IE  10
`define CSM_BIT_AUTO_BW_IE  11
`define CSM_BIT_EQ_IE       1
`define CSM_BIT_BW_MGMT_ST  14
`define CSM_BIT_AUTO_BW_ST  15
`define CSM_BIT_EQ_REQ      5
`define CSM_OBFF_LSB        13
`define CSM_OBFF_MSB        14
`define CSM_DPA_LSB         0
`define CSM_DPA_MSB         4
`define CSM_TPH_EN_BIT      8
`define CSM_TPH_MODE_LSB    0
`define CSM_TPH_MODE_MSB    2

// Reset values
`define CSM_RST_WORD        32'h0000_0000
`define CSM_RST_DPA         5'h00
`define CSM_RST_MODE3       3'h0

`endif

// ===== shared/csm_pkg.sv
// Types shared by the status mirror modules
package csm_pkg;

    // Role of the core on the link
    typedef enum logic {
        CSM_ENDPOINT  = 1'b0,
        CSM_ROOT_PORT = 1'b1
    } csm_port_mode_t;

    // Buffer flush/fill enable encodings
    typedef enum logic [1:0] {
        CSM_OBFF_OFF   = 2'b00,
        CSM_OBFF_MSG_A = 2'b01,
        CSM_OBFF_MSG_B = 2'b10,
        CSM_OBFF_WAKE  = 2'b11
    } csm_obff_mode_t;

    // Steering-tag mode select of one function
    typedef logic [2:0] csm_st_mode_t;

endpackage

// ===== rtl/csm_tph_slot.sv
// Steering-hint requester control store of one function
`timescale 1ns/1ps

`include "csm_defines.svh"

module csm_tph_slot
    import csm_pkg::*;
(
    input  wire logic          core_clk_in,   // Core clock
    input  wire logic          arst_n_in,     // Async reset, active low
    input  wire logic          wr_in,         // Write hit on this slot
    input  wire logic [31:0]   data_in,       // Write data
    output      logic          enable_out,    // Requester enable copy
    output      csm_st_mode_t  mode_out       // Steering-tag mode copy
);

    // Both fields flop straight from the write, one cycle latency
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            enable_out <= 1'b0;
            mode_out   <= `CSM_RST_MODE3;
        end else if (wr_in) begin
            enable_out <= data_in[`CSM_TPH_EN_BIT];
            mode_out   <= data_in[`CSM_TPH_MODE_MSB:`CSM_TPH_MODE_LSB];
        end
    end

endmodule

// ===== rtl/csm_status_mirror.sv
// Configuration status mirror: register copies and link event pulses
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps

`include "csm_defines.svh"

module csm_status_mirror
    import csm_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk_in,
    input  wire logic        arst_n_in,
    // Configuration register port
    input  wire logic [7:0]  addr_in,
    input  wire logic [31:0] wr_data_in,
    input  wire logic        wr_en_in,
    input  wire logic        rd_en_in,
    output      logic [31:0] rd_data_out,
    // Link layer events, one-cycle pulses; link_up_in is a level
    input  wire logic        link_up_in,
    input  wire logic        bw_change_local_in,
    input  wire logic        bw_change_remote_in,
    input  wire logic        eq_request_in,
    // Status mirrors to user logic
    output      logic [1:0]  rcb_status_out,
    output      logic [1:0]  dpa_substate_change_out,
    output      logic [1:0]  obff_enable_out,
    output      logic        link_event_pulse_out,
    output      logic [1:0]  steering_hint_req_enable_pf_out,
    output      logic [5:0]  steering_tag_mode_pf_out,
    output      logic [5:0]  steering_hint_req_enable_vf_out,
    output      logic [17:0] steering_tag_mode_vf_out
);

    // ------------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------------

    logic wr_mode;          // Port mode register hit
    logic wr_lctl_pf0;      // Link control PF0 hit
    logic wr_lctl_pf1;      // Link control PF1 hit
    logic wr_devctl2;       // Device control 2 hit
    logic wr_dpa_pf0;       // Power allocation control PF0 hit
    logic wr_dpa_pf1;       // Power allocation control PF1 hit
    logic wr_lctl3;         // Link control 3 hit
    logic wr_lsts;          // Link status hit (clear by one)
    logic wr_lsts2;         // Link status 2 hit (clear by one)
    logic tph_region;       // Address falls in the requester block

    // Plain equality compares, a masked compare for the requester block; unmapped writes are dropped silently
    assign wr_mode     = wr_en_in && (addr_in == `CSM_OFS_MODE);
    assign wr_lctl_pf0 = wr_en_in && (addr_in == `CSM_OFS_LINKCTL_PF0);
    assign wr_lctl_pf1 = wr_en_in && (addr_in == `CSM_OFS_LINKCTL_PF1);
    assign wr_devctl2  = wr_en_in && (addr_in == `CSM_OFS_DEVCTL2);
    assign wr_dpa_pf0  = wr_en_in && (addr_in == `CSM_OFS_DPACTL_PF0);
    assign wr_dpa_pf1  = wr_en_in && (addr_in == `CSM_OFS_DPACTL_PF1);
    assign wr_lctl3    = wr_en_in && (addr_in == `CSM_OFS_LINKCTL3);
    assign wr_lsts     = wr_en_in && (addr_in == `CSM_OFS_LINKSTS);
    assign wr_lsts2    = wr_en_in && (addr_in == `CSM_OFS_LINKSTS2);
    assign tph_region  = ((addr_in & `CSM_TPH_MASK) == `CSM_OFS_TPH_BASE);

    // ------------------------------------------------------------------
    // Configuration copies
    // ------------------------------------------------------------------

    csm_port_mode_t port_mode;      // Endpoint or root port
    logic [1:0]     rcb_cfg;        // Boundary bit per PF
    logic           bw_mgmt_ie;     // Bandwidth management int enable
    logic           auto_bw_ie;     // Autonomous bandwidth int enable
    logic           eq_ie;          // Equalization int enable
    csm_obff_mode_t obff_cfg;       // Flush/fill enable field
    logic [4:0]     dpa_pf0;        // Power allocation substate PF0
    logic [4:0]     dpa_pf1;        // Power allocation substate PF1

    // Next values, so the mirrors can follow in one cycle
    csm_port_mode_t next_port_mode;
    logic [1:0]     next_rcb_cfg;
    csm_obff_mode_t next_obff_cfg;

    // Next-state view of the written fields
    always_comb begin
        next_port_mode = port_mode;
        next_rcb_cfg   = rcb_cfg;
        next_obff_cfg  = obff_cfg;
        if (wr_mode) begin
            next_port_mode = csm_port_mode_t'(wr_data_in[`CSM_BIT_ROOT]);
        end
        if (wr_lctl_pf0) begin
            next_rcb_cfg[0] = wr_data_in[`CSM_BIT_RCB];
        end
        if (wr_lctl_pf1) begin
            next_rcb_cfg[1] = wr_data_in[`CSM_BIT_RCB];
        end
        if (wr_devctl2) begin
            next_obff_cfg = csm_obff_mode_t'(
                wr_data_in[`CSM_OBFF_MSB:`CSM_OBFF_LSB]);
        end
    end

    // Stored fields; the root port's own controls live in PF0's copy
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            port_mode  <= CSM_ENDPOINT;
            rcb_cfg    <= 2'h0;
            obff_cfg   <= CSM_OBFF_OFF;
            bw_mgmt_ie <= 1'b0;
            auto_bw_ie <= 1'b0;
            eq_ie      <= 1'b0;
        end else begin
            port_mode <= next_port_mode;
            rcb_cfg   <= next_rcb_cfg;
            obff_cfg  <= next_obff_cfg;
            // Interrupt enables of the root port
            if (wr_lctl_pf0) begin
                bw_mgmt_ie <= wr_data_in[`CSM_BIT_BW_MGMT_IE];
                auto_bw_ie <= wr_data_in[`CSM_BIT_AUTO_BW_IE];
            end
            if (wr_lctl3) begin
                eq_ie <= wr_data_in[`CSM_BIT_EQ_IE];
            end
        end
    end

    // ------------------------------------------------------------------
    // Boundary and flush/fill mirrors
    // ------------------------------------------------------------------

    // Output flops take the next value so they lag the write by one
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rcb_status_out  <= 2'h0;
            obff_enable_out <= 2'h0;
        end else begin
            // Root port: bit0 is its own, bit1 reserved and zero
            if (next_port_mode == CSM_ROOT_PORT) begin
                rcb_status_out <= {1'b0, next_rcb_cfg[0]};
            end else begin
                rcb_status_out <= next_rcb_cfg;
            end
            obff_enable_out <= next_obff_cfg;
        end
    end

    // ------------------------------------------------------------------
    // Power allocation substate change pulses
    // ------------------------------------------------------------------

    // A rewrite of the same substate is not a change, so no pulse
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            dpa_pf0                 <= `CSM_RST_DPA;
            dpa_pf1                 <= `CSM_RST_DPA;
            dpa_substate_change_out <= 2'h0;
        end else begin
            if (wr_dpa_pf0) begin
                dpa_pf0 <= wr_data_in[`CSM_DPA_MSB:`CSM_DPA_LSB];
            end
            if (wr_dpa_pf1) begin
                dpa_pf1 <= wr_data_in[`CSM_DPA_MSB:`CSM_DPA_LSB];
            end
            // Pulses only for an endpoint; held low in root mode
            dpa_substate_change_out[0] <= wr_dpa_pf0
                && (port_mode == CSM_ENDPOINT)
                && (wr_data_in[`CSM_DPA_MSB:`CSM_DPA_LSB] != dpa_pf0);
            dpa_substate_change_out[1] <= wr_dpa_pf1
                && (port_mode == CSM_ENDPOINT)
                && (wr_data_in[`CSM_DPA_MSB:`CSM_DPA_LSB] != dpa_pf1);
        end
    end

    // ------------------------------------------------------------------
    // Link events and their status bits
    // ------------------------------------------------------------------

    logic bw_mgmt_st;       // Local bandwidth change recorded
    logic auto_bw_st;       // Autonomous bandwidth change recorded
    logic eq_req_st;        // Equalization request recorded
    logic ev_local;         // Qualified local bandwidth event
    logic ev_remote;        // Qualified remote bandwidth event
    logic is_root;          // Root port operation

    assign is_root   = (port_mode == CSM_ROOT_PORT);
    // A local width or speed change that took the link down does not count
    assign ev_local  = is_root && bw_change_local_in && link_up_in;
    assign ev_remote = is_root && bw_change_remote_in;

    // Sticky status; an event in the clearing cycle still sets the bit
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            bw_mgmt_st <= 1'b0;
            auto_bw_st <= 1'b0;
            eq_req_st  <= 1'b0;
        end else begin
            bw_mgmt_st <= ev_local
                || (bw_mgmt_st
                    && !(wr_lsts && wr_data_in[`CSM_BIT_BW_MGMT_ST]));
            auto_bw_st <= ev_remote
                || (auto_bw_st
                    && !(wr_lsts && wr_data_in[`CSM_BIT_AUTO_BW_ST]));
            eq_req_st  <= eq_request_in
                || (eq_req_st
                    && !(wr_lsts2 && wr_data_in[`CSM_BIT_EQ_REQ]));
        end
    end

    // One-cycle event pulse; endpoint mode gates every source off
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            link_event_pulse_out <= 1'b0;
        end else begin
            link_event_pulse_out <= is_root
                && ((ev_local && bw_mgmt_ie)
                    || (ev_remote && auto_bw_ie)
                    || (eq_request_in && eq_ie));
        end
    end

    // ------------------------------------------------------------------
    // Steering-hint requester controls, PF0, PF1 then VF0..VF5
    // ------------------------------------------------------------------

    logic [7:0]   tph_en;                   // Requester enable per slot
    csm_st_mode_t tph_mode [`CSM_NUM_TPH];  // Mode select per slot
    logic [7:0]   tph_wr;                   // Write hit per slot

    // One store per function; write hit from the slot index bits
    genvar gi;
    generate
        for (gi = 0; gi < `CSM_NUM_TPH; gi = gi + 1) begin : g_tph
            assign tph_wr[gi] = wr_en_in && tph_region
                && (addr_in[`CSM_TPH_IDX_MSB:`CSM_TPH_IDX_LSB] == 3'(gi));
            csm_tph_slot u_slot (
                .core_clk_in (core_clk_in),
                .arst_n_in   (arst_n_in),
                .wr_in       (tph_wr[gi]),
                .data_in     (wr_data_in),
                .enable_out  (tph_en[gi]),
                .mode_out    (tph_mode[gi])
            );
        end
    endgenerate

    // Slot flops feed the ports directly, no extra stage
    assign steering_hint_req_enable_pf_out = tph_en[1:0];
    assign steering_hint_req_enable_vf_out = tph_en[7:2];
    assign steering_tag_mode_pf_out = {tph_mode[1], tph_mode[0]};
    assign steering_tag_mode_vf_out = {tph_mode[7], tph_mode[6],
                                       tph_mode[5], tph_mode[4],
                                       tph_mode[3], tph_mode[2]};

    // ------------------------------------------------------------------
    // Read back
    // ------------------------------------------------------------------

    logic [31:0] next_rd_data;  // Word selected by the address

    // Unmapped addresses and reserved bits read as zero
    always_comb begin
        next_rd_data = `CSM_RST_WORD;
        case (addr_in)
            `CSM_OFS_MODE: begin
                next_rd_data[`CSM_BIT_ROOT] = port_mode;
            end
            `CSM_OFS_LINKCTL_PF0: begin
                next_rd_data[`CSM_BIT_RCB]        = rcb_cfg[0];
                next_rd_data[`CSM_BIT_BW_MGMT_IE] = bw_mgmt_ie;
                next_rd_data[`CSM_BIT_AUTO_BW_IE] = auto_bw_ie;
            end
            `CSM_OFS_LINKCTL_PF1: begin
                next_rd_data[`CSM_BIT_RCB] = rcb_cfg[1];
            end
            `CSM_OFS_DEVCTL2: begin
                next_rd_data[`CSM_OBFF_MSB:`CSM_OBFF_LSB] = obff_cfg;
            end
            `CSM_OFS_DPACTL_PF0: begin
                next_rd_data[`CSM_DPA_MSB:`CSM_DPA_LSB] = dpa_pf0;
            end
            `CSM_OFS_DPACTL_PF1: begin
                next_rd_data[`CSM_DPA_MSB:`CSM_DPA_LSB] = dpa_pf1;
            end
            `CSM_OFS_LINKCTL3: begin
                next_rd_data[`CSM_BIT_EQ_IE] = eq_ie;
            end
            `CSM_OFS_LINKSTS: begin
                next_rd_data[`CSM_BIT_BW_MGMT_ST] = bw_mgmt_st;
                next_rd_data[`CSM_BIT_AUTO_BW_ST] = auto_bw_st;
            end
            `CSM_OFS_LINKSTS2: begin
                next_rd_data[`CSM_BIT_EQ_REQ] = eq_req_st;
            end
            default: begin
                // Requester block: eight consecutive words
                if (tph_region) begin
                    next_rd_data[`CSM_TPH_EN_BIT] =
                        tph_en[addr_in[`CSM_TPH_IDX_MSB:`CSM_TPH_IDX_LSB]];
                    next_rd_data[`CSM_TPH_MODE_MSB:`CSM_TPH_MODE_LSB] =
                        tph_mode[addr_in[`CSM_TPH_IDX_MSB:`CSM_TPH_IDX_LSB]];
                end
            end
        endcase
    end

    // Data valid only in the cycle after the strobe, zero otherwise
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rd_data_out <= `CSM_RST_WORD;
        end else if (rd_en_in) begin
            rd_data_out <= next_rd_data;
        end else begin
            rd_data_out <= `CSM_RST_WORD;
        end
    end

endmodule

// ===== verif/csm_status_mirror_props.sv
// Port-level assertions for the configuration status mirror
`timescale 1ns/1ps
`include "csm_defines.svh"
module csm_status_mirror_props
    import csm_pkg::*;
(
    input wire logic        core_clk_in,
    input wire logic        arst_n_in,
    input wire logic [7:0]  addr_in,
    input wire logic [31:0] wr_data_in,
    input wire logic        wr_en_in,
    input wire logic        link_up_in,
    input wire logic        bw_change_local_in,
    input wire logic        bw_change_remote_in,
    input wire logic        eq_request_in,
    input wire logic [1:0]  rcb_status_out,
    input wire logic [1:0]  dpa_substate_change_out,
    input wire logic [1:0]  obff_enable_out,
    input wire logic        link_event_pulse_out,
    input wire logic [5:0]  steering_hint_req_enable_vf_out,
    input wire logic [17:0] steering_tag_mode_vf_out
);
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!arst_n_in);

    logic       root;    // Shadow role, 1 = root port
    logic       bw_ie;   // Local bandwidth event enable
    logic       auto_ie; // Autonomous bandwidth event enable
    logic       eq_ie;   // Equalization event enable
    logic [4:0] dpa0;    // Shadow substate of PF0
    logic       ev_c;    // Event cause this cycle
    logic       dpa_c0;  // Substate change write on PF0

    // Shadow of gating fields, as stored before each edge
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            {root, bw_ie, auto_ie, eq_ie, dpa0} <= '0;
        end else if (wr_en_in) begin
            case (addr_in)
                `CSM_OFS_MODE:        root <= wr_data_in[0];
                `CSM_OFS_LINKCTL_PF0: {auto_ie, bw_ie} <= wr_data_in[11:10];
                `CSM_OFS_LINKCTL3:    eq_ie <= wr_data_in[1];
                `CSM_OFS_DPACTL_PF0:  dpa0 <= wr_data_in[4:0];
                default: ;
            endcase
        end
    end

    // Local change counts only while the link stays up
    assign ev_c = root && ((bw_change_local_in && link_up_in && bw_ie)
                  || (bw_change_remote_in && auto_ie)
                  || (eq_request_in && eq_ie));
    assign dpa_c0 = !root && wr_en_in && addr_in == `CSM_OFS_DPACTL_PF0
                    && wr_data_in[4:0] != dpa0;

    sequence s_remote_ev;
        root && auto_ie && bw_change_remote_in;
    endsequence
    sequence s_one_pulse;
        link_event_pulse_out ##1 !link_event_pulse_out;
    endsequence

    a_event_cause: assert property (
        link_event_pulse_out == $past(ev_c))
        else $error("link event pulse differs from its cause");
    a_remote_pulse: assert property (
        s_remote_ev |=> s_one_pulse)
        else $error("remote change gave no single pulse");
    a_dpa_pf0_pulse: assert property (
        dpa_substate_change_out[0] == $past(dpa_c0))
        else $error("substate pulse of PF0 wrong");
    a_dpa_root_low: assert property (
        root |=> dpa_substate_change_out == 2'h0)
        else $error("substate pulse in root mode");
    a_rcb_pf0_copy: assert property (
        wr_en_in && addr_in == `CSM_OFS_LINKCTL_PF0
        |=> rcb_status_out[0] == $past(wr_data_in[3]))
        else $error("boundary bit 0 not mirrored");
    a_obff_copy: assert property (
        wr_en_in && addr_in == `CSM_OFS_DEVCTL2
        |=> obff_enable_out == $past(wr_data_in[14:13]))
        else $error("flush/fill field not mirrored");
    a_obff_steady: assert property (
        !wr_en_in |=> $stable(obff_enable_out))
        else $error("flush/fill output moved without a write");
    a_tph_vf5_copy: assert property (
        wr_en_in && addr_in == `CSM_OFS_TPH_BASE + 8'h1C
        |=> steering_hint_req_enable_vf_out[5] == $past(wr_data_in[8])
        && steering_tag_mode_vf_out[17:15] == $past(wr_data_in[2:0]))
        else $error("VF5 steering fields not mirrored");
endmodule

bind csm_status_mirror csm_status_mirror_props u_props (.*);

// ===== verif/csm_user_model.sv
// User-side logic that consumes the mirror's event pulses
`timescale 1ns/1ps
module csm_user_model (
    input  wire logic       core_clk_in,  // Core clock
    input  wire logic       arst_n_in,    // Async reset, active low
    input  wire logic       ev_pulse_in,  // Link event pulse
    input  wire logic [1:0] dpa_pulse_in, // Substate change pulses
    output      logic [7:0] ev_cnt_out,   // Link events counted
    output      logic [7:0] dpa_cnt_out   // Substate changes counted
);
    // Counts per cycle; a stretched pulse would be counted twice
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ev_cnt_out <= 8'h00;
        end else begin
            ev_cnt_out <= ev_cnt_out + 8'(ev_pulse_in);
        end
    end

    // Both functions share one tally
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            dpa_cnt_out <= 8'h00;
        end else begin
            dpa_cnt_out <= dpa_cnt_out + 8'(dpa_pulse_in[0])
                           + 8'(dpa_pulse_in[1]);
        end
    end
endmodule

// ===== verif/tb.sv
// Self-checking bench for the configuration status mirror
`timescale 1ns/1ps
`include "csm_defines.svh"
module tb;
    logic        core_clk_in = 1'h0;
    logic        arst_n_in = 1'h0;
    logic [7:0]  addr_in = 8'h00;
    logic [31:0] wr_data_in = 32'h0000_0000;
    logic        wr_en_in = 1'h0;
    logic        rd_en_in = 1'h0;
    logic        link_up_in = 1'h1;
    logic        bw_change_local_in = 1'h0;
    logic        bw_change_remote_in = 1'h0;
    logic        eq_request_in = 1'h0;
    logic [31:0] rd_data_out;
    logic [1:0]  rcb_status_out;
    logic [1:0]  dpa_substate_change_out;
    logic [1:0]  obff_enable_out;
    logic        link_event_pulse_out;
    logic [1:0]  steering_hint_req_enable_pf_out;
    logic [5:0]  steering_tag_mode_pf_out;
    logic [5:0]  steering_hint_req_enable_vf_out;
    logic [17:0] steering_tag_mode_vf_out;
    logic [7:0]  ev_cnt;
    logic [7:0]  dpa_cnt;
    int          num_errors = 0;
    int          checks_done = 0;

    always #5 core_clk_in = ~core_clk_in;

    csm_status_mirror u_dut (.*);

    csm_user_model u_user (
        .core_clk_in, .arst_n_in, .ev_pulse_in(link_event_pulse_out),
        .dpa_pulse_in(dpa_substate_change_out), .ev_cnt_out(ev_cnt),
        .dpa_cnt_out(dpa_cnt)
    );

    // Four-state compare, an unknown matches only the same unknown
    task automatic cmp(input string w, input logic [31:0] e,
                       input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", w, e, g);
        end
    endtask

    // Past the next edge
    task automatic tick();
        @(posedge core_clk_in);
        #1;
    endtask

    // One-cycle write
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_in);
        wr_en_in   <= 1'h1;
        addr_in    <= a;
        wr_data_in <= d;
        @(posedge core_clk_in);
        wr_en_in <= 1'h0;
        #1;
    endtask

    // Read; data taken the cycle after
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk_in);
        rd_en_in <= 1'h1;
        addr_in  <= a;
        @(posedge core_clk_in);
        rd_en_in <= 1'h0;
        #1;
        d = rd_data_out;
    endtask

    // One-cycle link event {eq, remote, local}; expect pulse x once
    task automatic ev(input logic [2:0] k, input logic up, input logic x);
        @(posedge core_clk_in);
        {eq_request_in, bw_change_remote_in, bw_change_local_in} <= k;
        link_up_in <= up;
        @(posedge core_clk_in);
        {eq_request_in, bw_change_remote_in, bw_change_local_in} <= 3'h0;
        #1;
        cmp("link_event", x, link_event_pulse_out);
        tick();
        cmp("link_event_end", 1'h0, link_event_pulse_out);
    endtask

    task automatic done(input string n);
        $display("test %s finished", n);
    endtask

    // Boundary bits per PF, and root masking of bit 1
    task automatic test_rcb();
        cmp("reset_mirrors", 32'h0, {rcb_status_out, obff_enable_out,
            steering_hint_req_enable_vf_out, steering_tag_mode_vf_out});
        wr(`CSM_OFS_LINKCTL_PF0, 32'h0000_0008);
        cmp("rcb_pf0", 2'h1, rcb_status_out);
        wr(`CSM_OFS_LINKCTL_PF1, 32'h0000_0008);
        wr(`CSM_OFS_LINKCTL_PF0, 32'h0000_0000);
        cmp("rcb_pf1", 2'h2, rcb_status_out);
        wr(`CSM_OFS_MODE, 32'h0000_0001);
        tick();
        cmp("rcb_root", 2'h0, rcb_status_out);
        wr(`CSM_OFS_LINKCTL_PF0, 32'h0000_0008);
        cmp("rcb_root_own", 2'h1, rcb_status_out);
        wr(`CSM_OFS_MODE, 32'h0000_0000);
        tick();
        cmp("rcb_endpoint", 2'h3, rcb_status_out);
        done("rcb");
    endtask

    // Every flush/fill code, then held
    task automatic test_obff();
        for (int i = 0; i < 4; i++) begin
            wr(`CSM_OFS_DEVCTL2, 32'(i) << 13);
            cmp("obff", 32'(i), obff_enable_out);
        end
        tick();
        tick();
        cmp("obff_held", 2'h3, obff_enable_out);
        done("obff");
    endtask

    // All eight requester slots
    task automatic test_tph();
        logic [31:0] d;
        logic [7:0]  en;
        logic [23:0] md;
        for (int k = 0; k < 8; k++) begin
            d = 32'(k % 2) << 8 | 32'(1 - k % 2) << 9 | 32'(7 - k);
            en[k] = d[8];
            md[3*k +: 3] = d[2:0];
            wr(`CSM_OFS_TPH_BASE + 8'(4 * k), d);
        end
        cmp("req_en_pf", en[1:0], steering_hint_req_enable_pf_out);
        cmp("mode_pf", md[5:0], steering_tag_mode_pf_out);
        cmp("req_en_vf", en[7:2], steering_hint_req_enable_vf_out);
        cmp("mode_vf", md[23:6], steering_tag_mode_vf_out);
        done("tph");
    endtask

    // Substate pulses
    task automatic test_dpa();
        wr(`CSM_OFS_DPACTL_PF0, 32'h0000_0003);
        cmp("dpa_pf0", 2'h1, dpa_substate_change_out);
        tick();
        cmp("dpa_one_cycle", 2'h0, dpa_substate_change_out);
        wr(`CSM_OFS_DPACTL_PF0, 32'h0000_0003);
        cmp("dpa_same", 2'h0, dpa_substate_change_out);
        wr(`CSM_OFS_DPACTL_PF1, 32'h0000_001F);
        cmp("dpa_pf1", 2'h2, dpa_substate_change_out);
        wr(`CSM_OFS_MODE, 32'h0000_0001);
        wr(`CSM_OFS_DPACTL_PF0, 32'h0000_0004);
        cmp("dpa_root", 2'h0, dpa_substate_change_out);
        cmp("dpa_user_count", 8'h02, dpa_cnt);
        wr(`CSM_OFS_MODE, 32'h0000_0000);
        done("dpa");
    endtask

    // Link events in both roles
    task automatic test_events();
        logic [31:0] d;
        wr(`CSM_OFS_LINKCTL_PF0, 32'h0000_0C00);
        wr(`CSM_OFS_LINKCTL3, 32'h0000_0002);
        ev(3'h2, 1'h1, 1'h0);
        ev(3'h4, 1'h1, 1'h0);
        rd(`CSM_OFS_LINKSTS2, d);
        cmp("eq_status", 32'h0000_0020, d & 32'h0000_0020);
        wr(`CSM_OFS_MODE, 32'h0000_0001);
        ev(3'h1, 1'h1, 1'h1);
        rd(`CSM_OFS_LINKSTS, d);
        cmp("bw_status", 32'h0000_4000, d & 32'h0000_C000);
        wr(`CSM_OFS_LINKSTS, 32'h0000_C000);
        ev(3'h1, 1'h0, 1'h0);
        ev(3'h2, 1'h1, 1'h1);
        ev(3'h4, 1'h1, 1'h1);
        wr(`CSM_OFS_LINKCTL_PF0, 32'h0000_0000);
        wr(`CSM_OFS_LINKSTS, 32'h0000_C000);
        ev(3'h2, 1'h1, 1'h0);
        rd(`CSM_OFS_LINKSTS, d);
        cmp("auto_status", 32'h0000_8000, d & 32'h0000_C000);
        rd(8'hFC, d);
        cmp("unmapped_read", 32'h0000_0000, d);
        cmp("event_user_count", 8'h03, ev_cnt);
        done("events");
    endtask

    // Counts, verdict, stop
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Main sequence after a three-cycle reset
    initial begin
        repeat (3) @(posedge core_clk_in);
        arst_n_in <= 1'h1;
        tick();
        test_rcb();
        test_obff();
        test_tph();
        test_dpa();
        test_events();
        end_of_test();
    end

    // Run takes about a hundred cycles
    initial begin
        repeat (3000) @(posedge core_clk_in);
        num_errors++;
        end_of_test();
    end
endmodule
